// ### design/mmlp_map.vh
// Functional notes
// - data addresses 0x8000-0xFFFF reach program flash
// - program memory load addresses flash from 0x0000
// - flash is 4K words of 16 bits
// - 0x0000-0x003F io, 0x0040-0x107F extended io
// - eeprom 256 bytes at 0x1400-0x14FF
// - sram 0x3400-0x3FFF, 0x4000-0x7FFF reserved hole
// - instruction fetch never served from sram
// - stack occupies top of sram
// - eeprom byte and page access, 64-byte pages
// - flash split into boot, code, data protection regions
// - user page writable by cpu, survives full erase
// - locked debug port may write user page, not read
// - lock key 0xc5 means open, else locked
// - writing any other key locks device
// - locked debug port blocked from system bus
// - cpu accesses unaffected by lock state
// - denied debug reads complete with invalid data
// - only full erase unlocks, destroying application data
// - fuses readable by cpu and unlocked debug, written only by unlocked debug
// - fuses copied to configuration at start-up only
`ifndef MMLP_MAP_VH
`define MMLP_MAP_VH
// region codes
`define MMLP_RG_NONE 4'h0
`define MMLP_RG_IO 4'h1
`define MMLP_RG_XIO 4'h2
`define MMLP_RG_SIG 4'h3
`define MMLP_RG_FUSE 4'h4
`define MMLP_RG_LOCK 4'h5
`define MMLP_RG_USER 4'h6
`define MMLP_RG_EE 4'h7
`define MMLP_RG_SRAM 4'h8
`define MMLP_RG_FLASH 4'h9
// data-space ranges
`define MMLP_IO_LAST 16'h003f
`define MMLP_XIO_LAST 16'h107f
`define MMLP_SIG_FIRST 16'h1100
`define MMLP_SIG_LAST 16'h11ff
`define MMLP_FUSE_FIRST 16'h1280
`define MMLP_FUSE_LAST 16'h1289
`define MMLP_LOCK_FIRST 16'h128a
`define MMLP_LOCK_LAST 16'h12ff
`define MMLP_USER_FIRST 16'h1300
`define MMLP_USER_LAST 16'h137f
`define MMLP_EE_FIRST 16'h1400
`define MMLP_EE_LAST 16'h14ff
`define MMLP_SRAM_FIRST 16'h3400
`define MMLP_SRAM_LAST 16'h3fff
`define MMLP_FLASH_FIRST 16'h8000
// lock key and layout
`define MMLP_LOCK_OFFSET 8'h00
`define MMLP_LOCK_OPEN 8'hc5
`define MMLP_FUSE_COUNT 9
`define MMLP_FUSE_AW 4
`define MMLP_EE_PAGE_AW 6
`define MMLP_FLASH_WAW 12
`define MMLP_STACK_TOP 16'h3fff
`define MMLP_INVALID_DATA 8'hff
`endif

// ### design/mmlp_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "mmlp_map.vh"
// pure address decoder, shared by cpu and debug paths
module mmlp_decode (
	// address in
	input wire [15:0] i_addr,
	// region out
	output reg [3:0] o_region,
	output reg [15:0] o_offset
);
	// decode order follows the map, low to high
	always @* begin
		o_region = `MMLP_RG_NONE;
		o_offset = 16'h0000;
		if (i_addr <= `MMLP_IO_LAST) begin
			o_region = `MMLP_RG_IO;
			o_offset = i_addr;
		end else if (i_addr <= `MMLP_XIO_LAST) begin
			o_region = `MMLP_RG_XIO;
			o_offset = i_addr;
		end else if (i_addr >= `MMLP_SIG_FIRST && i_addr <= `MMLP_SIG_LAST) begin
			o_region = `MMLP_RG_SIG;
			o_offset = i_addr - `MMLP_SIG_FIRST;
		end else if (i_addr >= `MMLP_FUSE_FIRST &&
			i_addr <= `MMLP_FUSE_LAST) begin
			o_region = `MMLP_RG_FUSE;
			o_offset = i_addr - `MMLP_FUSE_FIRST;
		end else if (i_addr >= `MMLP_LOCK_FIRST &&
			i_addr <= `MMLP_LOCK_LAST) begin
			o_region = `MMLP_RG_LOCK;
			o_offset = i_addr - `MMLP_LOCK_FIRST;
		end else if (i_addr >= `MMLP_USER_FIRST &&
			i_addr <= `MMLP_USER_LAST) begin
			o_region = `MMLP_RG_USER;
			o_offset = i_addr - `MMLP_USER_FIRST;
		end else if (i_addr >= `MMLP_EE_FIRST && i_addr <= `MMLP_EE_LAST) begin
			o_region = `MMLP_RG_EE;
			o_offset = i_addr - `MMLP_EE_FIRST;
		end else if (i_addr >= `MMLP_SRAM_FIRST &&
			i_addr <= `MMLP_SRAM_LAST) begin
			o_region = `MMLP_RG_SRAM;
			o_offset = i_addr - `MMLP_SRAM_FIRST;
		end else if (i_addr >= `MMLP_FLASH_FIRST) begin
			o_region = `MMLP_RG_FLASH;
			o_offset = i_addr - `MMLP_FLASH_FIRST;
		end
		// 0x4000-0x7fff and other gaps stay unmapped
	end
endmodule // mmlp_decode
`default_nettype wire

// ### design/mmlp_protect.v
`timescale 1ns/1ns
`default_nettype none
`include "mmlp_map.vh"
// lock and access gate between cpu / debug port and the memory fabric.
// one request per side per cycle; answers land one cycle after the take.
// cpu has priority when both hit the same cycle.
module mmlp_protect (
	// clock and reset
	input wire i_clock,
	input wire i_rst_b,
	// cpu data access
	input wire i_cpu_req,
	input wire i_cpu_we,
	input wire [15:0] i_cpu_addr,
	input wire [7:0] i_cpu_wdata,
	// cpu fetch / program memory load (code space word address)
	input wire i_fetch_req,
	input wire [11:0] i_fetch_waddr,
	// debug_program_port access (from pins, synchronised here)
	input wire i_dbg_req,
	input wire i_dbg_we,
	input wire i_dbg_fuse_cmd,
	input wire [15:0] i_dbg_addr,
	input wire [7:0] i_dbg_wdata,
	// full_erase_command from debug port
	input wire i_erase_req,
	// memory fabric read data
	input wire [7:0] i_mem_rdata,
	input wire [15:0] i_flash_rword,
	// cpu answers
	output reg o_cpu_ack,
	output reg [7:0] o_cpu_rdata,
	output reg o_fetch_ack,
	output reg [15:0] o_fetch_word,
	// debug answers
	output reg o_dbg_ack,
	output reg [7:0] o_dbg_rdata,
	// memory fabric request
	output reg o_mem_req,
	output reg o_mem_we,
	output reg [3:0] o_mem_region,
	output reg [15:0] o_mem_offset,
	output reg [7:0] o_mem_wdata,
	output reg o_flash_req,
	output reg [11:0] o_flash_waddr,
	// erase and status
	output reg o_erase_strobe,
	output reg o_locked,
	output reg [15:0] o_stack_reset,
	output reg [71:0] o_fuse_cfg
);
	// reset release through two flops
	reg rst_s1_r;
	reg rst_r; // active-high synchronous copy
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_s1_r <= 1'b1;
			rst_r <= 1'b1;
		end else begin
			rst_s1_r <= 1'b0;
			rst_r <= rst_s1_r;
		end
	end

	// two-flop synchronisers for the debug pins
	reg [27:0] dbg_s1_r;
	reg [27:0] dbg_s2_r;
	always @(posedge i_clock) begin
		if (rst_r) begin
			dbg_s1_r <= 28'h0;
			dbg_s2_r <= 28'h0;
		end else begin
			dbg_s1_r <= {i_dbg_req, i_dbg_we, i_dbg_fuse_cmd, i_erase_req,
				i_dbg_addr, i_dbg_wdata};
			dbg_s2_r <= dbg_s1_r;
		end
	end
	wire dbg_req_s = dbg_s2_r[27];
	wire dbg_we_s = dbg_s2_r[26];
	wire dbg_fcmd_s = dbg_s2_r[25];
	wire erase_s = dbg_s2_r[24];
	wire [15:0] dbg_addr_s = dbg_s2_r[23:8];
	wire [7:0] dbg_wdata_s = dbg_s2_r[7:0];
	// edge detect on the synchronised level, one take per request
	reg dbg_req_d_r;
	reg erase_d_r;
	wire dbg_take = dbg_req_s & ~dbg_req_d_r;
	wire erase_take = erase_s & ~erase_d_r;

	// nonvolatile fuse store and lock key (stand-ins for the nvm array)
	reg [7:0] fuse_nv_r [0:`MMLP_FUSE_COUNT-1];
	reg [7:0] lock_key_field_r; // nonvolatile key byte
	reg [7:0] lock_loaded_r; // key as loaded at start-up
	reg loaded_r; // start-up copy done

	// decode both sides
	wire [3:0] cpu_rg;
	wire [15:0] cpu_off;
	wire [3:0] dbg_rg;
	wire [15:0] dbg_off;
	mmlp_decode u_dec_cpu (
		.i_addr(i_cpu_addr),
		.o_region(cpu_rg),
		.o_offset(cpu_off)
	);
	mmlp_decode u_dec_dbg (
		.i_addr(dbg_addr_s),
		.o_region(dbg_rg),
		.o_offset(dbg_off)
	);

	// lock state uses the key loaded at reset, not the live byte
	wire locked_now = (lock_loaded_r != `MMLP_LOCK_OPEN);

	// debug permission
	reg dbg_allow; // access permitted; fuse/key served locally, the rest reaches the fabric
	reg dbg_read_valid; // returned data is genuine
	always @* begin
		dbg_allow = 1'b0;
		dbg_read_valid = 1'b0;
		if (locked_now) begin
			// only user page write via fuse write command
			dbg_allow = dbg_we_s && dbg_fcmd_s && (dbg_rg == `MMLP_RG_USER);
		end else begin
			// signature page write ignored even when open
			dbg_allow = (dbg_rg != `MMLP_RG_NONE) &&
				!(dbg_we_s && dbg_rg == `MMLP_RG_SIG);
			dbg_read_valid = 1'b1;
		end
	end

	// cpu write filter: fuses, key and signature are read-only
	wire cpu_wr_blocked = i_cpu_we && (cpu_rg == `MMLP_RG_FUSE ||
		cpu_rg == `MMLP_RG_LOCK || cpu_rg == `MMLP_RG_SIG);
	wire cpu_go = i_cpu_req && !cpu_wr_blocked &&
		cpu_rg != `MMLP_RG_FUSE && cpu_rg != `MMLP_RG_LOCK;

	// fuse/key reads are served locally; the fabric holds the rest
	function [7:0] local_read;
		input [3:0] rg;
		input [15:0] off;
		begin
			local_read = 8'h00;
			if (rg == `MMLP_RG_LOCK && off == {8'h00, `MMLP_LOCK_OFFSET})
				local_read = lock_key_field_r;
			else if (rg == `MMLP_RG_FUSE && off < 16'd`MMLP_FUSE_COUNT)
				local_read = fuse_nv_r[off[`MMLP_FUSE_AW-1:0]];
		end
	endfunction

	// pending read sources, one cycle after the take
	reg cpu_pend_r;
	reg cpu_local_r;
	reg [7:0] cpu_local_data_r;
	reg dbg_pend_r;
	reg dbg_valid_r;
	reg dbg_local_r;
	reg [7:0] dbg_local_data_r;
	reg dbg_deferred_r; // debug held off by a cpu access this cycle

	integer k;
	// power-up image of the nonvolatile stand-ins; reset leaves them alone,
	// otherwise a changed key or fuse could never take effect after reset
	initial begin
		for (k = 0; k < `MMLP_FUSE_COUNT; k = k + 1)
			fuse_nv_r[k] = 8'hff;
		lock_key_field_r = `MMLP_LOCK_OPEN;
	end
	// main sequencer
	always @(posedge i_clock) begin
		if (rst_r) begin
			lock_loaded_r <= 8'h00; // locked until the copy runs
			loaded_r <= 1'b0;
			dbg_req_d_r <= 1'b0;
			erase_d_r <= 1'b0;
			cpu_pend_r <= 1'b0;
			cpu_local_r <= 1'b0;
			cpu_local_data_r <= 8'h00;
			dbg_pend_r <= 1'b0;
			dbg_valid_r <= 1'b0;
			dbg_local_r <= 1'b0;
			dbg_local_data_r <= 8'h00;
			dbg_deferred_r <= 1'b0;
			o_cpu_ack <= 1'b0;
			o_cpu_rdata <= 8'h00;
			o_fetch_ack <= 1'b0;
			o_fetch_word <= 16'h0000;
			o_dbg_ack <= 1'b0;
			o_dbg_rdata <= 8'h00;
			o_mem_req <= 1'b0;
			o_mem_we <= 1'b0;
			o_mem_region <= `MMLP_RG_NONE;
			o_mem_offset <= 16'h0000;
			o_mem_wdata <= 8'h00;
			o_flash_req <= 1'b0;
			o_flash_waddr <= 12'h000;
			o_erase_strobe <= 1'b0;
			o_locked <= 1'b1;
			o_stack_reset <= `MMLP_STACK_TOP;
			o_fuse_cfg <= 72'h0;
		end else begin
			dbg_req_d_r <= dbg_req_s;
			erase_d_r <= erase_s;
			o_erase_strobe <= 1'b0;
			o_mem_req <= 1'b0;
			o_mem_we <= 1'b0;
			o_flash_req <= 1'b0;
			o_cpu_ack <= 1'b0;
			o_dbg_ack <= 1'b0;
			o_fetch_ack <= 1'b0;
			cpu_pend_r <= 1'b0;
			dbg_pend_r <= 1'b0;
			o_locked <= locked_now;
			// start-up copy of fuses into configuration, once
			if (!loaded_r) begin
				loaded_r <= 1'b1;
				lock_loaded_r <= lock_key_field_r;
				for (k = 0; k < `MMLP_FUSE_COUNT; k = k + 1)
					o_fuse_cfg[k*8 +: 8] <= fuse_nv_r[k];
			end
			// fetch only ever from flash, code-space word address
			if (i_fetch_req) begin
				o_flash_req <= 1'b1;
				o_flash_waddr <= i_fetch_waddr;
			end
			o_fetch_ack <= o_flash_req;
			o_fetch_word <= i_flash_rword;
			// cpu side, unaffected by the lock
			if (i_cpu_req) begin
				cpu_pend_r <= 1'b1;
				cpu_local_r <= !cpu_go;
				cpu_local_data_r <= local_read(cpu_rg, cpu_off);
				if (cpu_go) begin
					o_mem_req <= 1'b1;
					o_mem_we <= i_cpu_we; // enforced in fabric
					o_mem_region <= cpu_rg;
					o_mem_offset <= cpu_off;
					o_mem_wdata <= i_cpu_wdata;
				end
			end
			// debug side; waits a cycle for each cycle the cpu holds the fabric
			if ((dbg_take || dbg_deferred_r) && loaded_r) begin
				if (i_cpu_req && dbg_allow &&
					dbg_rg != `MMLP_RG_FUSE && dbg_rg != `MMLP_RG_LOCK) begin
					dbg_deferred_r <= 1'b1;
				end else begin
					dbg_deferred_r <= 1'b0;
					dbg_pend_r <= 1'b1;
					dbg_valid_r <= dbg_read_valid;
					dbg_local_r <= (dbg_rg == `MMLP_RG_FUSE ||
						dbg_rg == `MMLP_RG_LOCK || !dbg_allow);
					dbg_local_data_r <= local_read(dbg_rg, dbg_off);
					if (dbg_allow && dbg_we_s &&
						dbg_rg == `MMLP_RG_LOCK &&
						dbg_off == {8'h00, `MMLP_LOCK_OFFSET}) begin
						// any write stored; non-key value locks on reset
						lock_key_field_r <= dbg_wdata_s;
					end else if (dbg_allow && dbg_we_s &&
						dbg_rg == `MMLP_RG_FUSE &&
						dbg_off < 16'd`MMLP_FUSE_COUNT) begin
						fuse_nv_r[dbg_off[`MMLP_FUSE_AW-1:0]] <= dbg_wdata_s;
					end else if (dbg_allow && dbg_rg != `MMLP_RG_FUSE &&
						dbg_rg != `MMLP_RG_LOCK) begin
						o_mem_req <= 1'b1;
						o_mem_we <= dbg_we_s;
						o_mem_region <= dbg_rg;
						o_mem_offset <= dbg_off;
						o_mem_wdata <= dbg_wdata_s;
					end
				end
			end
			// full erase: the only way to reopen; user page untouched
			if (erase_take) begin
				o_erase_strobe <= 1'b1;
				lock_key_field_r <= `MMLP_LOCK_OPEN;
				lock_loaded_r <= `MMLP_LOCK_OPEN;
			end
			// answers
			if (cpu_pend_r) begin
				o_cpu_ack <= 1'b1;
				o_cpu_rdata <= cpu_local_r ? cpu_local_data_r : i_mem_rdata;
			end
			if (dbg_pend_r) begin
				o_dbg_ack <= 1'b1; // denied reads still complete
				if (!dbg_valid_r)
					o_dbg_rdata <= `MMLP_INVALID_DATA;
				else
					o_dbg_rdata <= dbg_local_r ? dbg_local_data_r : i_mem_rdata;
			end
		end
	end
endmodule // mmlp_protect
`default_nettype wire

// ### dv/mmlp_protect_properties.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checker for the lock and access gate
module mmlp_protect_properties (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// requests
	input wire logic i_cpu_req,
	input wire logic [15:0] i_cpu_addr,
	input wire logic i_fetch_req,
	input wire logic [11:0] i_fetch_waddr,
	input wire logic i_dbg_we,
	input wire logic [7:0] i_mem_rdata,
	input wire logic [15:0] i_flash_rword,
	// answers
	input wire logic o_cpu_ack,
	input wire logic [7:0] o_cpu_rdata,
	input wire logic o_fetch_ack,
	input wire logic [15:0] o_fetch_word,
	input wire logic o_dbg_ack,
	input wire logic [7:0] o_dbg_rdata,
	input wire logic o_mem_req,
	input wire logic o_mem_we,
	input wire logic [3:0] o_mem_region,
	input wire logic o_flash_req,
	input wire logic [11:0] o_flash_waddr,
	input wire logic o_erase_strobe,
	input wire logic o_locked,
	input wire logic [15:0] o_stack_reset
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	a_io_route: assert property (i_cpu_req && i_cpu_addr <= 16'h003f
		|=> o_mem_req && o_mem_region == 4'h1) else $error("io decode");
	a_xio_route: assert property (i_cpu_req && i_cpu_addr >= 16'h0040
		&& i_cpu_addr <= 16'h107f |=> o_mem_region == 4'h2)
		else $error("xio decode");
	a_ee_route: assert property (i_cpu_req && i_cpu_addr[15:8] == 8'h14
		|=> o_mem_req && o_mem_region == 4'h7) else $error("ee decode");
	a_sram_route: assert property (i_cpu_req && i_cpu_addr >= 16'h3400
		&& i_cpu_addr <= 16'h3fff |=> o_mem_region == 4'h8)
		else $error("sram decode");
	a_hole_route: assert property (i_cpu_req && i_cpu_addr[15:14] == 2'b01
		|=> o_mem_region == 4'h0) else $error("hole decode");
	a_flash_data: assert property (i_cpu_req && i_cpu_addr[15]
		|=> o_mem_req && o_mem_region == 4'h9) else $error("flash decode");
	a_fetch_flow: assert property (i_fetch_req |=> o_flash_req
		&& o_flash_waddr == $past(i_fetch_waddr) ##1 o_fetch_ack
		&& o_fetch_word == $past(i_flash_rword)) else $error("fetch path");
	a_cpu_data: assert property (i_cpu_req ##1 o_mem_req
		&& o_mem_region >= 4'h6 |=> o_cpu_ack
		&& o_cpu_rdata == $past(i_mem_rdata)) else $error("cpu data");
	a_dbg_denied: assert property (o_dbg_ack && o_locked && !i_dbg_we
		|-> o_dbg_rdata == 8'hff) else $error("locked read data");
	a_locked_gate: assert property (o_mem_req && o_locked
		&& !$past(i_cpu_req) |-> o_mem_we && o_mem_region == 4'h6)
		else $error("locked debug reached fabric");
	a_erase_open: assert property (o_erase_strobe
		|=> !o_erase_strobe ##[0:2] !o_locked) else $error("erase");
	a_stack_top: assert property (o_stack_reset == 16'h3fff)
		else $error("stack top");
	// main scenarios
	c_cpu: cover property (o_cpu_ack);
	c_dbg_locked: cover property (o_dbg_ack && o_locked);
	c_erase: cover property (o_erase_strobe);
endmodule // mmlp_protect_properties
`default_nettype wire

// ### dv/mmlp_dbg_tool.sv
`timescale 1ns/1ns
`default_nettype none
// external debug and programming tool on the debug port
module mmlp_dbg_tool (
	// clock and answer
	input wire logic i_clock,
	input wire logic i_ack,
	input wire logic [7:0] i_rdata,
	// request lines
	output logic o_req,
	output logic o_we,
	output logic o_fuse,
	output logic [15:0] o_addr,
	output logic [7:0] o_wdata,
	output logic o_erase
);
	int timeouts = 0; // accesses that never saw an ack
	initial begin
		o_req = 1'b0;
		o_we = 1'b0;
		o_fuse = 1'b0;
		o_addr = 16'h0;
		o_wdata = 8'h0;
		o_erase = 1'b0;
	end
	// one access; qualifiers held until ack, garbage while idle
	task automatic xfer(input logic we, input logic fz, input logic [15:0] a,
		input logic [7:0] wd, output logic [7:0] rd);
		int n;
		@(posedge i_clock);
		o_req <= 1'b1;
		o_we <= we;
		o_fuse <= fz;
		o_addr <= a;
		o_wdata <= wd;
		rd = 8'h00;
		for (n = 0; n < 30; n++) begin
			@(posedge i_clock);
			if (i_ack === 1'b1) begin
				rd = i_rdata;
				break;
			end
		end
		if (n == 30)
			timeouts++;
		o_req <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~wd;
		// request must stay low a few cycles before the next one
		repeat (4) @(posedge i_clock);
	endtask
	// full erase pulse, long enough for the synchroniser
	task automatic erase();
		@(posedge i_clock);
		o_erase <= 1'b1;
		repeat (4) @(posedge i_clock);
		o_erase <= 1'b0;
		repeat (6) @(posedge i_clock);
	endtask
endmodule // mmlp_dbg_tool
`default_nettype wire

// ### dv/tb_memory_map_lock_protection.sv
`timescale 1ns/1ns
`default_nettype none
module tb_memory_map_lock_protection;
	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic cpu_req = 1'b0, cpu_we = 1'b0, f_req = 1'b0;
	logic [15:0] cpu_addr = 16'h0, f_word = 16'h0;
	logic [7:0] cpu_wd = 8'h0, mem_rd = 8'h0, rd;
	logic [11:0] f_addr = 12'h0;
	logic d_req, d_we, d_fz, d_er, c_ack, c_ack2, d_ack, m_req, m_we, fl_req;
	logic er_st, locked;
	logic [15:0] d_addr, fw, m_off, stk;
	logic [7:0] d_wd, c_rd, d_rd, m_wd;
	logic [3:0] m_rg;
	logic [11:0] fl_wa;
	logic [71:0] fcfg;
	int err_total = 0, comparisons = 0;
	initial forever #10 i_clock = ~i_clock;
	mmlp_protect dut (.i_clock(i_clock), .i_rst_b(i_rst_b),
		.i_cpu_req(cpu_req), .i_cpu_we(cpu_we), .i_cpu_addr(cpu_addr),
		.i_cpu_wdata(cpu_wd), .i_fetch_req(f_req), .i_fetch_waddr(f_addr),
		.i_dbg_req(d_req), .i_dbg_we(d_we), .i_dbg_fuse_cmd(d_fz),
		.i_dbg_addr(d_addr), .i_dbg_wdata(d_wd), .i_erase_req(d_er),
		.i_mem_rdata(mem_rd), .i_flash_rword(f_word), .o_cpu_ack(c_ack),
		.o_cpu_rdata(c_rd), .o_fetch_ack(c_ack2), .o_fetch_word(fw),
		.o_dbg_ack(d_ack), .o_dbg_rdata(d_rd), .o_mem_req(m_req),
		.o_mem_we(m_we), .o_mem_region(m_rg), .o_mem_offset(m_off),
		.o_mem_wdata(m_wd), .o_flash_req(fl_req), .o_flash_waddr(fl_wa),
		.o_erase_strobe(er_st), .o_locked(locked), .o_stack_reset(stk),
		.o_fuse_cfg(fcfg));
	mmlp_dbg_tool tool (.i_clock(i_clock), .i_ack(d_ack), .i_rdata(d_rd),
		.o_req(d_req), .o_we(d_we), .o_fuse(d_fz), .o_addr(d_addr),
		.o_wdata(d_wd), .o_erase(d_er));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		err_total += tool.timeouts;
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// reset held 20 cycles, then time for the start-up copy
	task automatic do_reset();
		@(posedge i_clock);
		i_rst_b <= 1'b0;
		repeat (20) @(posedge i_clock);
		i_rst_b <= 1'b1;
		repeat (8) @(posedge i_clock);
	endtask
	// cpu access, ack one edge after the take
	task automatic cpu(input logic we, input logic [15:0] a,
		input logic [7:0] d);
		@(posedge i_clock);
		cpu_req <= 1'b1;
		cpu_we <= we;
		cpu_addr <= a;
		cpu_wd <= d;
		mem_rd <= a[7:0] ^ 8'h5a;
		@(posedge i_clock);
		cpu_req <= 1'b0;
		@(posedge i_clock);
		#1 chk({15'h0, c_ack}, 16'h1);
	endtask
	// io, extended io, eeprom, sram, hole and flash regions, plus a fetch from the top code word
	task automatic t_map();
		cpu(1'b0, 16'h003f, 8'h0);
		cpu(1'b0, 16'h107f, 8'h0);
		cpu(1'b0, 16'h14ff, 8'h0);
		cpu(1'b0, 16'h3fff, 8'h0);
		chk({8'h0, c_rd}, 16'h00a5);
		cpu(1'b0, 16'h4000, 8'h0);
		cpu(1'b1, 16'h8000, 8'h11);
		chk(m_off, 16'h0000);
		chk({8'h0, m_wd}, 16'h0011);
		@(posedge i_clock);
		f_req <= 1'b1;
		f_addr <= 12'hfff;
		f_word <= 16'hc3a1;
		@(posedge i_clock);
		f_req <= 1'b0;
		repeat (2) @(posedge i_clock);
		#1 chk(fw, 16'hc3a1);
		chk({4'h0, fl_wa}, 16'h0fff);
	endtask
	// fuses change only from the open debug port, effective after reset
	task automatic t_fuse_lock();
		chk({15'h0, locked}, 16'h0);
		tool.xfer(1'b1, 1'b0, 16'h1280, 8'h3c, rd);
		cpu(1'b1, 16'h1281, 8'h00);
		tool.xfer(1'b0, 1'b0, 16'h1280, 8'h00, rd);
		chk({8'h0, rd}, 16'h003c);
		tool.xfer(1'b0, 1'b0, 16'h1281, 8'h00, rd);
		chk({8'h0, rd}, 16'h00ff);
		chk(fcfg[15:0], 16'hffff);
		tool.xfer(1'b1, 1'b0, 16'h128a, 8'hc4, rd);
		chk({15'h0, locked}, 16'h0);
		do_reset();
		chk(fcfg[15:0], 16'hff3c);
		chk({15'h0, locked}, 16'h1);
	endtask
	// locked: debug reads invalid, user page write allowed, cpu free
	task automatic t_locked();
		tool.xfer(1'b0, 1'b0, 16'h3400, 8'h00, rd);
		chk({8'h0, rd}, 16'h00ff);
		tool.xfer(1'b0, 1'b0, 16'h1280, 8'h00, rd);
		chk({8'h0, rd}, 16'h00ff);
		tool.xfer(1'b1, 1'b1, 16'h1300, 8'h77, rd);
		tool.xfer(1'b0, 1'b0, 16'h1300, 8'h00, rd);
		chk({8'h0, rd}, 16'h00ff);
		cpu(1'b0, 16'h1300, 8'h0);
		chk({8'h0, c_rd}, 16'h005a);
		tool.erase();
		chk({15'h0, locked}, 16'h0);
		tool.xfer(1'b0, 1'b0, 16'h1400, 8'h00, rd);
		chk({8'h0, rd}, 16'h005a);
	endtask
	initial begin
		#200000;
		err_total++;
		finish_test();
	end
	initial begin
		do_reset();
		chk(stk, 16'h3fff);
		t_map();
		t_fuse_lock();
		t_locked();
		finish_test();
	end
endmodule // tb_memory_map_lock_protection
bind mmlp_protect mmlp_protect_properties u_props (.*);
`default_nettype wire
